// ==== hw/clkgen_pkg.sv ====
// shared constants, field layouts and state types for the dual pll clock generator
package clkgen_pkg;

   // ==========================================================
   // register offsets (byte addresses, one word each)
   // ==========================================================
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_MULT   = 8'h04;
   localparam logic [7:0] OFF_DIV_A  = 8'h08;
   localparam logic [7:0] OFF_DIV_B  = 8'h0C;
   localparam logic [7:0] OFF_GPIO   = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;

   // ==========================================================
   // field positions
   // ==========================================================
   localparam int CTRL_PREDIV_LSB  = 0;
   localparam int CTRL_BYPASS_BIT  = 2;
   localparam int CTRL_PIN_GPIO    = 3;
   localparam int CTRL_MEMCLK_EXT  = 4;
   localparam int CTRL_ETH_FROMREF = 5;
   localparam int CTRL_ETH_DIV5    = 6;
   localparam int GPIO_OUT_BIT     = 0;
   localparam int GPIO_DRIVE_BIT   = 1;
   localparam int STAT_MAIN_LOCK   = 0;
   localparam int STAT_MEM_LOCK    = 1;
   localparam int STAT_PIN_LEVEL   = 2;

   // ==========================================================
   // reset values and fixed ratios (ratios held as value minus one, except MEM_PLL_MULT)
   // ==========================================================
   localparam logic [6:0] CTRL_RESET      = 7'h04;
   localparam logic [4:0] MULT_M1_RESET   = 5'h00;
   localparam logic [4:0] DIV_M1_RESET    = 5'h00;
   localparam logic [4:0] FIXED_DIV3_M1   = 5'h02;
   localparam logic [4:0] FIXED_DIV6_M1   = 5'h05;
   localparam logic [5:0] MEM_PLL_MULT    = 6'h14;
   localparam logic [4:0] MEM_HALF_M1     = 5'h01;
   localparam logic [4:0] ETH_DIV2_M1     = 5'h01;
   localparam logic [4:0] ETH_DIV5_M1     = 5'h04;
   localparam logic [1:0] PREDIV_MAX_M1   = 2'h2;
   localparam logic [15:0] PERIOD_MAX     = 16'hFFFF;

   // ==========================================================
   // carriers
   // ==========================================================
   typedef struct packed {
      logic       eth_div5;
      logic       eth_from_ref;
      logic       memclk_ext;
      logic       pin_gpio;
      logic       bypass;
      logic [1:0] prediv;
   } cfg_t;

   typedef struct packed {
      logic [4:0] cnt;
      logic       pulse;
   } div_t;

   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] period;
      logic [16:0] acc;
      logic        seen;
      logic        locked;
      logic        tick;
   } pll_state_t;

   typedef struct packed {
      cfg_t            cfg;
      logic [4:0]      mult_m1;
      logic [4:0]      div_a_m1;
      logic [4:0]      div_b_m1;
      logic            gpio_out;
      logic            gpio_drive;
      logic [2:0]      main_sync;
      logic [2:0]      mem_sync;
      logic [2:0]      ext_sync;
      logic [1:0]      pin_sync;
      logic [1:0]      prediv_cnt;
      logic            main_ref_tick;
      logic [3:0][4:0] post_cnt;
      logic [3:0]      sys_tick;
      logic            fourth_level;
      logic            async_tick;
      logic [4:0]      half_cnt;
      logic            ddr_tick;
      logic [4:0]      eth_cnt;
      logic            eth_tick;
      logic            wr_pend;
      logic [7:0]      wr_addr;
      logic [31:0]     rdata;
   } main_state_t;

endpackage : clkgen_pkg

// ==== hw/tick_pll.sv ====
// digital pll model: emits mult output ticks per reference period
module tick_pll
   import clkgen_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ref_tick,
   input  wire logic [5:0] mult,
   output logic            out_tick,
   output logic            locked
);

   pll_state_t s;
   pll_state_t next_s;
   logic [16:0] sum;

   // ==========================================================
   // period measurement and rate accumulator
   // ==========================================================
   always_comb begin
      next_s      = s;
      next_s.tick = 1'b0;
      sum         = s.acc + {11'h000, mult};
      if (ref_tick) begin
         next_s.period = s.cnt + 16'h0001;
         next_s.cnt    = 16'h0000;
         next_s.seen   = 1'b1;
         next_s.locked = s.seen;
      end else if (s.cnt == PERIOD_MAX) begin
         // reference stopped: drop lock rather than run on a stale period
         next_s.locked = 1'b0;
         next_s.seen   = 1'b0;
      end else begin
         next_s.cnt = s.cnt + 16'h0001;
      end
      if (s.locked) begin
         // at most one tick per cycle: faster settings are out of range
         if (sum >= {1'b0, s.period}) begin
            next_s.tick = 1'b1;
            next_s.acc  = sum - {1'b0, s.period};
         end else begin
            next_s.acc = sum;
         end
      end else begin
         next_s.acc = 17'h0_0000;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign out_tick = s.tick;
   assign locked   = s.locked;

endmodule : tick_pll

// ==== hw/dual_pll_clock_generator.sv ====
// dual pll clock generator with ahb-lite register slave

// Operation
// RQ1 - main reference pre-divided by one, two, three
// RQ2 - main pll multiplies by one through 32
// RQ3 - bypass selects pll or raw reference
// RQ4 - two post-dividers fixed at three, six
// RQ5 - two post-dividers programmable one through 32
// RQ6 - shared pin: fourth clock or gpio bit
// RQ7 - async memory clock: fourth clock or external
// RQ8 - memory pll times 20, halved, to ddr2
// RQ9 - ethernet: halved pll or reference, /2 or /5
// RQ10 - software keeps all clocks within frequency limits
module dual_pll_clock_generator
   import clkgen_pkg::*;
(
   input  wire logic        MCLK,
   input  wire logic        RESET,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic [31:0]      HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        MAIN_REF_IN,
   input  wire logic        MEM_REF_IN,
   input  wire logic        EXT_MEMORY_CLOCK_IN,
   input  wire logic        SHARED_PIN_IN,
   output logic             SHARED_PIN_OUT,
   output logic             SHARED_PIN_OE_N,
   output logic [3:0]       SYSTEM_CLOCK_TICK,
   output logic             ASYNC_MEMORY_PORT_TICK,
   output logic             DDR_CLOCK_TICK,
   output logic             ETHERNET_MAC_BLOCK_TICK,
   output logic             MAIN_PLL_LOCKED,
   output logic             MEMORY_PLL_LOCKED
);

   main_state_t s;
   main_state_t next_s;
   logic        main_ref_edge;
   logic        mem_ref_edge;
   logic        ext_edge;
   logic        main_pll_tick;
   logic        memory_pll_tick;
   logic        main_lock;
   logic        mem_lock;
   logic        selected_tick;
   logic        eth_src_tick;
   logic        addr_phase;
   logic [4:0]  post_lim [4];
   div_t        step;

   // ==========================================================
   // helpers
   // ==========================================================
   function automatic div_t div_step(input logic [4:0] cnt,
                                     input logic [4:0] lim,
                                     input logic       tick);
      div_t r;
      r.cnt   = cnt;
      r.pulse = 1'b0;
      if (tick) begin
         // >= so a lowered ratio never leaves the count stranded above it
         if (cnt >= lim) begin
            r.cnt   = 5'h00;
            r.pulse = 1'b1;
         end else begin
            r.cnt = cnt + 5'h01;
         end
      end
      return r;
   endfunction : div_step

   function automatic logic [31:0] reg_read(input main_state_t v,
                                            input logic [7:0]  addr,
                                            input logic        lk_main,
                                            input logic        lk_mem,
                                            input logic        pin_lvl);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (addr)
         OFF_CTRL:   r = {25'h000_0000, v.cfg};
         OFF_MULT:   r = {27'h000_0000, v.mult_m1};
         OFF_DIV_A:  r = {27'h000_0000, v.div_a_m1};
         OFF_DIV_B:  r = {27'h000_0000, v.div_b_m1};
         OFF_GPIO:   r = {30'h0000_0000, v.gpio_drive, v.gpio_out};
         OFF_STATUS: begin
            r[STAT_MAIN_LOCK] = lk_main;
            r[STAT_MEM_LOCK]  = lk_mem;
            r[STAT_PIN_LEVEL] = pin_lvl;
         end
         default:    r = 32'h0000_0000;
      endcase
      return r;
   endfunction : reg_read

   // ==========================================================
   // plls
   // ==========================================================
   tick_pll u_main_pll (
      .clk      (MCLK),
      .rst      (RESET),
      .ref_tick (s.main_ref_tick),
      .mult     ({1'b0, s.mult_m1} + 6'h01),         // RQ2
      .out_tick (main_pll_tick),
      .locked   (main_lock)
   );

   tick_pll u_memory_pll (
      .clk      (MCLK),
      .rst      (RESET),
      .ref_tick (mem_ref_edge),
      .mult     (MEM_PLL_MULT),                       // RQ8
      .out_tick (memory_pll_tick),
      .locked   (mem_lock)
   );

   // ==========================================================
   // clock selection
   // ==========================================================
   assign main_ref_edge = s.main_sync[1] & ~s.main_sync[2];
   assign mem_ref_edge  = s.mem_sync[1] & ~s.mem_sync[2];
   assign ext_edge      = s.ext_sync[1] & ~s.ext_sync[2];
   assign selected_tick = s.cfg.bypass ? main_ref_edge : main_pll_tick;   // RQ3
   assign eth_src_tick  = s.cfg.eth_from_ref ? mem_ref_edge : s.ddr_tick; // RQ9
   assign addr_phase    = HSEL & HTRANS[1] & HREADY;

   assign post_lim[0] = s.div_a_m1;      // RQ5
   assign post_lim[1] = FIXED_DIV3_M1;   // RQ4
   assign post_lim[2] = FIXED_DIV6_M1;   // RQ4
   assign post_lim[3] = s.div_b_m1;      // RQ5

   // ==========================================================
   // next state
   // ==========================================================
   always_comb begin
      next_s = s;
      step   = '0;

      // pin synchronisers; stage 0 is read only by stage 1
      next_s.main_sync = {s.main_sync[1:0], MAIN_REF_IN};
      next_s.mem_sync  = {s.mem_sync[1:0], MEM_REF_IN};
      next_s.ext_sync  = {s.ext_sync[1:0], EXT_MEMORY_CLOCK_IN};
      next_s.pin_sync  = {s.pin_sync[0], SHARED_PIN_IN};

      // pre-divider; reserved code 3 behaves as divide by three
      next_s.main_ref_tick = 1'b0;
      if (main_ref_edge) begin
         if (s.prediv_cnt >= s.cfg.prediv || s.prediv_cnt >= PREDIV_MAX_M1) begin   // RQ1
            next_s.prediv_cnt    = 2'h0;
            next_s.main_ref_tick = 1'b1;
         end else begin
            next_s.prediv_cnt = s.prediv_cnt + 2'h1;
         end
      end

      // post-dividers
      for (int i = 0; i < 4; i++) begin
         step                = div_step(s.post_cnt[i], post_lim[i], selected_tick);   // RQ3
         next_s.post_cnt[i]  = step.cnt;
         next_s.sys_tick[i]  = step.pulse;
      end
      if (s.sys_tick[3]) begin
         next_s.fourth_level = ~s.fourth_level;
      end
      next_s.async_tick = s.cfg.memclk_ext ? ext_edge : s.sys_tick[3];   // RQ7

      // memory side
      step            = div_step(s.half_cnt, MEM_HALF_M1, memory_pll_tick);   // RQ8
      next_s.half_cnt = step.cnt;
      next_s.ddr_tick = step.pulse;
      step            = div_step(s.eth_cnt,
                                 s.cfg.eth_div5 ? ETH_DIV5_M1 : ETH_DIV2_M1,
                                 eth_src_tick);                               // RQ9
      next_s.eth_cnt  = step.cnt;
      next_s.eth_tick = step.pulse;

      // ahb-lite data phase of a write
      if (s.wr_pend) begin
         unique case (s.wr_addr)
            OFF_CTRL:  next_s.cfg      = cfg_t'(HWDATA[6:0]);
            OFF_MULT:  next_s.mult_m1  = HWDATA[4:0];
            OFF_DIV_A: next_s.div_a_m1 = HWDATA[4:0];
            OFF_DIV_B: next_s.div_b_m1 = HWDATA[4:0];
            OFF_GPIO: begin
               next_s.gpio_out   = HWDATA[GPIO_OUT_BIT];
               next_s.gpio_drive = HWDATA[GPIO_DRIVE_BIT];
            end
            default: next_s.wr_pend = 1'b0;
         endcase
      end

      // address phase; read data taken from next values so a read right
      // after a write to the same register sees the new contents
      next_s.wr_pend = addr_phase & HWRITE;
      next_s.wr_addr = HADDR[7:0];
      if (addr_phase && !HWRITE) begin
         next_s.rdata = (HADDR[31:8] == 24'h00_0000)
                        // pin level from the settled stage: next_s would expose stage 0
                        ? reg_read(next_s, HADDR[7:0], main_lock, mem_lock, s.pin_sync[1])
                        : 32'h0000_0000;
      end
      if (addr_phase && HADDR[31:8] != 24'h00_0000) begin
         next_s.wr_pend = 1'b0;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         s          <= '0;
         s.cfg      <= cfg_t'(CTRL_RESET);
         s.mult_m1  <= MULT_M1_RESET;
         s.div_a_m1 <= DIV_M1_RESET;
         s.div_b_m1 <= DIV_M1_RESET;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // outputs
   // ==========================================================
   assign HRDATA    = s.rdata;
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;

   // pin drives the fourth clock unless handed to the general io bit
   assign SHARED_PIN_OUT  = s.cfg.pin_gpio ? s.gpio_out : s.fourth_level;    // RQ6
   assign SHARED_PIN_OE_N = s.cfg.pin_gpio ? ~s.gpio_drive : 1'b0;           // RQ6

   assign SYSTEM_CLOCK_TICK       = s.sys_tick;
   assign ASYNC_MEMORY_PORT_TICK  = s.async_tick;
   assign DDR_CLOCK_TICK          = s.ddr_tick;
   assign ETHERNET_MAC_BLOCK_TICK = s.eth_tick;
   assign MAIN_PLL_LOCKED         = main_lock;
   assign MEMORY_PLL_LOCKED       = mem_lock;

endmodule : dual_pll_clock_generator

// ==== verification/dual_pll_clock_generator_chk.sv ====
// port-level assertion checker for the dual pll clock generator
module dual_pll_clock_generator_chk
   import clkgen_pkg::*;
(
   input wire logic        MCLK,
   input wire logic        RESET,
   input wire logic        HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0]  HTRANS,
   input wire logic        HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic        HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic        HREADYOUT,
   input wire logic        HRESP,
   input wire logic        SHARED_PIN_OE_N,
   input wire logic [3:0]  SYSTEM_CLOCK_TICK,
   input wire logic        ASYNC_MEMORY_PORT_TICK,
   input wire logic        DDR_CLOCK_TICK,
   input wire logic        ETHERNET_MAC_BLOCK_TICK,
   input wire logic        MAIN_PLL_LOCKED,
   input wire logic        MEMORY_PLL_LOCKED
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // shadow of the control register, rebuilt from bus writes
   // ==========================================================
   logic       wr_ctrl;
   logic [6:0] ctrl;
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         wr_ctrl <= 1'b0;
         ctrl    <= CTRL_RESET;
      end else begin
         wr_ctrl <= HSEL && HTRANS[1] && HREADY && HWRITE && HADDR == {24'h00_0000, OFF_CTRL};
         if (wr_ctrl) begin
            ctrl <= HWDATA[6:0];
         end
      end
   end

   // ==========================================================
   // properties
   // ==========================================================
   default clocking @(posedge MCLK); endclocking
   default disable iff (RESET);

   AST_OKAY: assert property (HREADYOUT && !HRESP)
      else $error("bus slave stalled or answered with an error");
   AST_RST_QUIET: assert property (disable iff (1'b0) RESET |=> SYSTEM_CLOCK_TICK == 4'h0
      && !MAIN_PLL_LOCKED && !MEMORY_PLL_LOCKED && HRDATA == 32'h0000_0000)
      else $error("outputs not quiet after reset");
   AST_ASYNC_SRC: assert property (!ctrl[CTRL_MEMCLK_EXT] |=>
      ASYNC_MEMORY_PORT_TICK == $past(SYSTEM_CLOCK_TICK[3]))
      else $error("async memory tick does not follow fourth clock");
   AST_PIN_CLK: assert property (!ctrl[CTRL_PIN_GPIO] && !$past(ctrl[CTRL_PIN_GPIO])
      |-> !SHARED_PIN_OE_N)
      else $error("shared pin not driven in clock mode");
   AST_DIV_ALIGN: assert property (SYSTEM_CLOCK_TICK[2] |-> SYSTEM_CLOCK_TICK[1])
      else $error("divide by six tick without divide by three tick");
   AST_DIV3_GAP: assert property (SYSTEM_CLOCK_TICK[1] |=> !SYSTEM_CLOCK_TICK[1] [*2])
      else $error("divide by three ticks too close");
   AST_DIV6_GAP: assert property (SYSTEM_CLOCK_TICK[2] |=> !SYSTEM_CLOCK_TICK[2] [*5])
      else $error("divide by six ticks too close");
   AST_DDR_HALF: assert property (DDR_CLOCK_TICK |=> !DDR_CLOCK_TICK)
      else $error("ddr ticks not halved");
   AST_ETH_DIV: assert property (ETHERNET_MAC_BLOCK_TICK |=> !ETHERNET_MAC_BLOCK_TICK)
      else $error("ethernet ticks too close");
   AST_FAR_READ: assert property (HSEL && HTRANS[1] && HREADY && !HWRITE
      && HADDR[31:8] != 24'h00_0000 |=> HRDATA == 32'h0000_0000)
      else $error("read outside the block returned data");
endmodule : dual_pll_clock_generator_chk

bind dual_pll_clock_generator dual_pll_clock_generator_chk u_chk (.*);

// ==== verification/test_dual_pll_clock_generator.sv ====
// self-checking testbench for the dual pll clock generator
module test_dual_pll_clock_generator;
   timeunit 1ns;
   timeprecision 1ns;
   import clkgen_pkg::*;
   logic        MCLK = 1'b0;
   logic        RESET, HSEL, HWRITE, MAIN_REF_IN, EXT_MEMORY_CLOCK_IN, SHARED_PIN_IN;
   logic        MEM_REF_IN = 1'b0;
   logic [31:0] HADDR, HWDATA, HRDATA, r;
   logic [1:0]  HTRANS;
   logic        HREADYOUT, HRESP, SHARED_PIN_OUT, SHARED_PIN_OE_N, ASYNC_MEMORY_PORT_TICK;
   logic        DDR_CLOCK_TICK, ETHERNET_MAC_BLOCK_TICK, MAIN_PLL_LOCKED, MEMORY_PLL_LOCKED;
   logic [3:0]  SYSTEM_CLOCK_TICK;
   logic [4:0]  ph = 5'h00;
   int          fail_count = 0;
   int          num_checks = 0;
   int          cyc = 0;
   int          c[8];

   dual_pll_clock_generator u_dut (.HREADY(HREADYOUT), .HSIZE(3'h2), .*);

   initial forever #10 MCLK = ~MCLK;

   // memory reference free-running, period 32 cycles, slow enough for x20
   always @(posedge MCLK) begin
      ph <= ph + 5'h01;
      MEM_REF_IN <= ph[4];
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         $display("[ERR] run time expected below 20000 seen %0d", cyc);
         stop_test;
      end
   end

   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test

   task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : cmp

   task automatic near(string n, int e, int g, int t);
      num_checks++;
      if (g < e - t || g > e + t) begin
         fail_count++;
         $display("[ERR] %s expected %0d seen %0d", n, e, g);
      end
   endtask : near

   // one single ahb-lite transfer; waits on hready, never on a fixed count
   task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
      @(posedge MCLK);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HWRITE <= w;
      HADDR <= a;
      do @(posedge MCLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= d;
      do @(posedge MCLK); while (HREADYOUT !== 1'b1);
      r = HRDATA;
   endtask : bus

   task automatic rc(string n, logic [31:0] a, logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      cmp(n, e, r);
   endtask : rc

   task automatic ref_run(int n, int h);
      repeat (n) begin
         @(posedge MCLK);
         MAIN_REF_IN <= 1'b1;
         repeat (h) @(posedge MCLK);
         MAIN_REF_IN <= 1'b0;
         repeat (h - 1) @(posedge MCLK);
      end
   endtask : ref_run

   // counts ticks per output and shared pin toggles, sampled mid-cycle
   task automatic window(int n);
      logic       last;
      logic [6:0] v;
      c = '{default: 0};
      last = SHARED_PIN_OUT;
      repeat (n) begin
         @(negedge MCLK);
         v = {ETHERNET_MAC_BLOCK_TICK, DDR_CLOCK_TICK, ASYNC_MEMORY_PORT_TICK, SYSTEM_CLOCK_TICK};
         for (int i = 0; i < 7; i++) begin
            c[i] += int'(v[i] === 1'b1);
         end
         c[7] += int'(SHARED_PIN_OUT !== last);
         last = SHARED_PIN_OUT;
      end
   endtask : window

   task automatic t_regs;
      rc("ctrl", OFF_CTRL, {25'h000_0000, CTRL_RESET});
      rc("mult", OFF_MULT, 32'h0000_0000);
      rc("div_a", OFF_DIV_A, 32'h0000_0000);
      rc("div_b", OFF_DIV_B, 32'h0000_0000);
      rc("gpio", OFF_GPIO, 32'h0000_0000);
      bus(1'b0, OFF_STATUS, 32'h0000_0000);
      cmp("main_lock", 32'h0000_0000, {31'h0000_0000, r[STAT_MAIN_LOCK]});
      bus(1'b1, OFF_MULT, 32'hFFFF_FFFF);
      rc("mult_max", OFF_MULT, 32'h0000_001F);
      bus(1'b1, 32'h0000_0018, 32'hFFFF_FFFF);
      rc("unmapped", 32'h0000_0018, 32'h0000_0000);
      rc("far", 32'h0000_0100, 32'h0000_0000);
      bus(1'b1, OFF_MULT, 32'h0000_0003);
      $display("test regs done");
   endtask : t_regs

   task automatic t_bypass;
      bus(1'b1, OFF_DIV_A, 32'h0000_0004);
      bus(1'b1, OFF_DIV_B, 32'h0000_0001);
      fork
         ref_run(30, 8);
         window(520);
      join
      near("div_a", 6, c[0], 0);
      near("div3", 10, c[1], 0);
      near("div6", 5, c[2], 0);
      near("div_b", 15, c[3], 0);
      near("async", 15, c[4], 0);
      near("pin_toggles", 15, c[7], 0);
      cmp("pin_oe", 32'h0000_0000, SHARED_PIN_OE_N);
      $display("test bypass done");
   endtask : t_bypass

   // x4 pll, pre-divide codes 0..3 (3 acts as /3), reference period 16 stays within limits
   task automatic t_pll;
      bus(1'b1, OFF_DIV_A, 32'h0000_0000);
      for (int p = 0; p < 4; p++) begin
         fork
            ref_run(45, 8);
            begin
               bus(1'b1, OFF_CTRL, 32'(p));
               repeat (200) @(posedge MCLK);
               window(480);
            end
         join
         near("main_ticks", (p == 3) ? 40 : 120 / (p + 1), c[0], 3);
         near("fourth", (p == 3) ? 20 : 60 / (p + 1), c[3], 3);
         cmp("main_lock", 32'h0000_0001, MAIN_PLL_LOCKED);
      end
      $display("test pll done");
   endtask : t_pll

   task automatic t_mem;
      int e[4] = '{100, 10, 40, 4};
      cmp("mem_lock", 32'h0000_0001, MEMORY_PLL_LOCKED);
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, OFF_CTRL, 32'h0000_0004 | 32'(k << 5));
         repeat (100) @(posedge MCLK);
         window(640);
         near("ddr_ticks", 200, c[5], 3);
         near("eth_ticks", e[k], c[6], 2);
      end
      $display("test memory pll done");
   endtask : t_mem

   task automatic t_pin;
      bus(1'b1, OFF_CTRL, 32'h0000_001C);
      bus(1'b1, OFF_GPIO, 32'h0000_0003);
      repeat (2) @(negedge MCLK);
      cmp("pin_out", 32'h0000_0001, SHARED_PIN_OUT);
      cmp("pin_oe_on", 32'h0000_0000, SHARED_PIN_OE_N);
      bus(1'b1, OFF_GPIO, 32'h0000_0001);
      SHARED_PIN_IN <= 1'b1;
      repeat (4) @(negedge MCLK);
      cmp("pin_oe_off", 32'h0000_0001, SHARED_PIN_OE_N);
      bus(1'b0, OFF_STATUS, 32'h0000_0000);
      cmp("pin_level", 32'h0000_0001, {31'h0000_0000, r[STAT_PIN_LEVEL]});
      fork
         window(60);
         repeat (5) begin
            @(posedge MCLK);
            EXT_MEMORY_CLOCK_IN <= 1'b1;
            repeat (3) @(posedge MCLK);
            EXT_MEMORY_CLOCK_IN <= 1'b0;
            repeat (3) @(posedge MCLK);
         end
      join
      near("ext_ticks", 5, c[4], 0);
      $display("test pin done");
   endtask : t_pin

   initial begin
      RESET = 1'b1;
      HSEL = 1'b0;
      HADDR = 32'h0000_0000;
      HTRANS = 2'h0;
      HWRITE = 1'b0;
      HWDATA = 32'h0000_0000;
      MAIN_REF_IN = 1'b0;
      EXT_MEMORY_CLOCK_IN = 1'b0;
      SHARED_PIN_IN = 1'b0;
      repeat (2) @(posedge MCLK);
      RESET <= 1'b0;
      t_regs;
      t_bypass;
      t_pll;
      t_mem;
      t_pin;
      stop_test;
   end
endmodule : test_dual_pll_clock_generator
